// File: verilog/cpu8_consts.svh
`ifndef CPU8_CONSTS_SVH
`define CPU8_CONSTS_SVH
`define RESET_PC 16'h0100
`define RESET_SP 8'hff
`define STACK_HI 8'h00
`define ZERO_HI 8'h00
`define OP_BITOPS_HI 4'h0
`define OP_BITSC_HI 4'h1
`define OP_BRANCH_HI 4'h2
`define OP_BSR 8'had
`define OP_CLC 8'h98
`define OP_CLI 8'h9a
`define OP_MUL 8'h42
`define LO_ADC 4'h9
`define LO_ADD 4'hb
`define LO_AND 4'h4
`define LO_BIT 4'h5
`define LO_ASL 4'h8
`define LO_ASR 4'h7
`define LO_TST 4'hd
`define MODE_DIR 4'h3
`define MODE_INHA 4'h4
`define MODE_INHX 4'h5
`define MODE_IX1R 4'h6
`define MODE_IXR 4'h7
`define MODE_IMM 4'ha
`define MODE_DIRM 4'hb
`define MODE_EXT 4'hc
`define MODE_IX2 4'hd
`define MODE_IX1 4'he
`define MODE_IX 4'hf
`define NIB_MASK 8'h0f
`define SIGN_BIT 7
`endif

// File: verilog/cpu8_pkg.sv
package cpu8_pkg;
	// Gray coded along fetch, address, read, exec, write
	typedef enum logic [3:0] {
		ST_FETCH = 4'h0,
		ST_OPA = 4'h1,
		ST_OPB = 4'h3,
		ST_READ = 4'h2,
		ST_EXEC = 4'h6,
		ST_WRITE = 4'h7,
		ST_PUSHL = 4'h5,
		ST_PUSHH = 4'h4,
		ST_IDLE = 4'hc
	} state_type;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] x;
		logic [7:0] sp;
		logic [15:0] pc;
		logic h, i, n, z, c;
		logic [7:0] op;
		logic [7:0] b1;
		logic [15:0] ea;
		logic [7:0] data;
		logic [7:0] wdata;
		logic [15:0] addr;
		logic rd, wr;
		logic [2:0] wait_cnt;
		state_type st;
	} cpu_type;
endpackage : cpu8_pkg

// File: verilog/cpu8_alu.sv
`timescale 1ns/1ps
`include "cpu8_consts.svh"
module cpu8_alu import cpu8_pkg::*; (
	input wire logic [3:0] i_lo,
	input wire logic i_rmw,
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_m,
	input wire logic i_c,
	output logic [7:0] o_res,
	output logic o_h,
	output logic o_c,
	output logic o_wr_a
);
	logic [8:0] sum;
	logic [4:0] hsum;
	// Operation select; unsupported codes pass the operand through
	always_comb begin
		sum = 9'h000;
		hsum = 5'h00;
		o_res = i_m;
		o_h = 1'b0;
		o_c = i_c;
		o_wr_a = 1'b0;
		if (i_rmw) begin
			case (i_lo)
				`LO_ASL: begin
					o_res = {i_m[6:0], 1'b0}; // [RQ20]
					o_c = i_m[7];
				end
				`LO_ASR: begin
					o_res = {i_m[7], i_m[7:1]}; // [RQ21] [RQ23]
					o_c = i_m[0];
				end
				default: o_res = i_m; // Test: no change [RQ3]
			endcase
		end else begin
			case (i_lo)
				`LO_ADC, `LO_ADD: begin
					sum = {1'b0, i_a} + {1'b0, i_m} + {8'h00, (i_lo == `LO_ADC) & i_c}; // [RQ16] [RQ17]
					hsum = {1'b0, i_a[3:0]} + {1'b0, i_m[3:0]} + {4'h0, (i_lo == `LO_ADC) & i_c};
					o_res = sum[7:0];
					o_c = sum[8];
					o_h = hsum[4];
					o_wr_a = 1'b1;
				end
				`LO_AND: begin
					o_res = i_a & i_m; // [RQ18]
					o_wr_a = 1'b1;
				end
				`LO_BIT: o_res = i_a & i_m; // Flags only [RQ19]
				default: o_res = i_m;
			endcase
		end
	end
endmodule : cpu8_alu

// File: verilog/cpu8_instruction_decode_exec.sv
`timescale 1ns/1ps
`include "cpu8_consts.svh"
// Contract
// RQ1: Register/memory ops take A plus memory operand
// RQ2: Read-modify-write reads, computes, writes back same place
// RQ3: Test op reads, sets flags, never writes
// RQ4: Bit set/clear use direct page only
// RQ5: Bit clear odd 11-1F, set even 10-1E
// RQ6: Bit branch: opcode, direct address, offset
// RQ7: Taken bit branch adds signed offset
// RQ8: Bit branch copies tested bit to carry
// RQ9: Branch-bit-set even 00-0E, clear odd 01-0F
// RQ10: Relative branch PC+2+offset when true
// RQ11: 20 always, 21 never, 22/23 on C or Z
// RQ12: 24/25 on carry, 26/27 on zero
// RQ13: 28/29 half-carry, 2A/2B negative flag
// RQ14: 2C/2D mask, 2E/2F interrupt pin
// RQ15: Relative call pushes PC low then high
// RQ16: Add with carry updates H N Z C
// RQ17: Add without carry updates H N Z C
// RQ18: AND stores result, updates N Z
// RQ19: Bit test sets N Z, keeps A
// RQ20: Shift left: zero in, bit 7 to carry
// RQ21: Arithmetic right: bit 0 to carry
// RQ22: 98 clears carry, 9A clears mask
// RQ23: Arithmetic right keeps sign bit
// RQ24: Direct mode high address byte is zero
// RQ25: Multiply puts high byte in X, low in A
module cpu8_instruction_decode_exec import cpu8_pkg::*; (
	input wire logic I_CLOCK,
	input wire logic I_RESET_N,
	input wire logic [7:0] I_RDATA,
	input wire logic I_IRQ_PIN,
	output logic [15:0] O_ADDR,
	output logic [7:0] O_WDATA,
	output logic O_RD,
	output logic O_WR,
	output logic [15:0] O_PC,
	output logic [7:0] O_ACC,
	output logic [7:0] O_INDEX,
	output logic [7:0] O_SP,
	output logic [4:0] O_FLAGS,
	output logic O_FETCH
);
	logic rst_meta_q, rst_sync_q;
	cpu_type s_q, s_d;
	logic [7:0] alu_res;
	logic alu_h, alu_c, alu_wr_a;
	logic [15:0] prod;
	logic [3:0] hi, lo;
	logic rmw;

	// Reset release through two stages
	always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// Sign-extended relative target
	function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] off);
		rel_target = base + {{8{off[`SIGN_BIT]}}, off};
	endfunction : rel_target

	// Condition table for the 0x2n branches
	function automatic logic branch_cond(input logic [3:0] code, input logic hf, input logic im,
		input logic nf, input logic zf, input logic cf, input logic pin);
		logic r;
		case (code[3:1])
			3'h0: r = 1'b1; // [RQ11]
			3'h1: r = ~(cf | zf); // [RQ11]
			3'h2: r = ~cf; // [RQ12]
			3'h3: r = ~zf; // [RQ12]
			3'h4: r = ~hf; // [RQ13]
			3'h5: r = ~nf; // [RQ13]
			3'h6: r = ~im; // [RQ14]
			default: r = ~pin; // [RQ14]
		endcase
		branch_cond = code[0] ? ~r : r;
	endfunction : branch_cond

	assign hi = s_q.op[7:4];
	assign lo = s_q.op[3:0];
	assign rmw = (hi == `MODE_DIR) || (hi == `MODE_INHA) || (hi == `MODE_INHX)
		|| (hi == `MODE_IX1R) || (hi == `MODE_IXR);
	assign prod = s_q.a * s_q.x;

	cpu8_alu u_alu (
		.i_lo(lo),
		.i_rmw(rmw),
		.i_a(s_q.a),
		.i_m(s_q.data),
		.i_c(s_q.c),
		.o_res(alu_res),
		.o_h(alu_h),
		.o_c(alu_c),
		.o_wr_a(alu_wr_a)
	);

	// Sequencer: one state per bus cycle; counts are not padded to the table
	always_comb begin
		s_d = s_q;
		s_d.rd = 1'b0;
		s_d.wr = 1'b0;
		case (s_q.st)
			ST_IDLE: begin
				s_d.addr = s_q.pc;
				s_d.rd = 1'b1;
				s_d.st = ST_FETCH;
			end
			ST_FETCH: begin
				s_d.op = I_RDATA;
				s_d.pc = s_q.pc + 16'h0001;
				s_d.wait_cnt = 3'h0;
				s_d.st = ST_OPA;
			end
			ST_OPA: begin
				// Decode the first operand fetch or inherent work
				// Multiply sits in the accumulator column, so it must win first
				if (s_q.op == `OP_MUL) begin
					s_d.x = prod[15:8]; // [RQ25]
					s_d.a = prod[7:0];
					s_d.h = 1'b0;
					s_d.c = 1'b0;
					s_d.st = ST_IDLE;
				end else if (hi == `MODE_INHA || hi == `MODE_INHX) begin
					s_d.data = (hi == `MODE_INHA) ? s_q.a : s_q.x; // [RQ2]
					s_d.st = ST_EXEC;
				end else if (s_q.op == `OP_CLC) begin
					s_d.c = 1'b0; // [RQ22]
					s_d.st = ST_IDLE;
				end else if (s_q.op == `OP_CLI) begin
					s_d.i = 1'b0; // [RQ22]
					s_d.st = ST_IDLE;
				end else if (hi == `MODE_IXR || hi == `MODE_IX) begin
					s_d.ea = {`ZERO_HI, s_q.x};
					s_d.addr = {`ZERO_HI, s_q.x};
					s_d.rd = 1'b1;
					s_d.st = ST_READ;
				end else begin
					s_d.addr = s_q.pc;
					s_d.rd = 1'b1;
					s_d.pc = s_q.pc + 16'h0001;
					s_d.st = ST_OPB;
				end
			end
			ST_OPB: begin
				s_d.b1 = I_RDATA;
				s_d.st = ST_READ;
				s_d.rd = 1'b1;
				if (hi == `OP_BITOPS_HI || hi == `OP_BITSC_HI || hi == `MODE_DIR
					|| hi == `MODE_DIRM) begin
					s_d.ea = {`ZERO_HI, I_RDATA}; // [RQ4] [RQ24]
					s_d.addr = {`ZERO_HI, I_RDATA};
				end else if (hi == `MODE_IX1 || hi == `MODE_IX1R) begin
					s_d.ea = {`ZERO_HI, I_RDATA} + {`ZERO_HI, s_q.x};
					s_d.addr = {`ZERO_HI, I_RDATA} + {`ZERO_HI, s_q.x};
				end else if (hi == `MODE_IMM && s_q.op != `OP_BSR) begin
					s_d.data = I_RDATA;
					s_d.rd = 1'b0;
					s_d.st = ST_EXEC;
				end else if (hi == `MODE_EXT || hi == `MODE_IX2) begin
					// Second address byte still to come
					if (s_q.wait_cnt == 3'h0) begin
						s_d.b1 = I_RDATA;
						s_d.addr = s_q.pc;
						s_d.pc = s_q.pc + 16'h0001;
						s_d.wait_cnt = 3'h1;
						s_d.st = ST_OPB;
					end else begin
						s_d.ea = {s_q.b1, I_RDATA} + ((hi == `MODE_IX2) ? {`ZERO_HI, s_q.x}
							: 16'h0000);
						s_d.addr = s_d.ea;
					end
				end else begin
					// Relative: branch or call, offset already in hand
					s_d.rd = 1'b0;
					s_d.st = ST_EXEC;
				end
			end
			ST_READ: begin
				s_d.data = I_RDATA;
				if (hi == `OP_BITOPS_HI) begin
					s_d.addr = s_q.pc; // Offset byte of bit branch [RQ6]
					s_d.pc = s_q.pc + 16'h0001;
					s_d.rd = 1'b1;
					s_d.st = ST_WRITE;
				end else begin
					s_d.st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				s_d.st = ST_IDLE;
				if (hi == `OP_BRANCH_HI) begin
					if (branch_cond(lo, s_q.h, s_q.i, s_q.n, s_q.z, s_q.c, I_IRQ_PIN))
						s_d.pc = rel_target(s_q.pc, s_q.b1); // [RQ10]
				end else if (s_q.op == `OP_BSR) begin
					s_d.addr = {`STACK_HI, s_q.sp};
					s_d.wdata = s_q.pc[7:0]; // Low byte first [RQ15]
					s_d.wr = 1'b1;
					s_d.sp = s_q.sp - 8'h01;
					s_d.st = ST_PUSHL;
				end else if (hi == `OP_BITSC_HI) begin
					s_d.wdata = lo[0] ? (s_q.data & ~(8'h01 << lo[3:1]))
						: (s_q.data | (8'h01 << lo[3:1])); // [RQ5]
					s_d.addr = s_q.ea;
					s_d.wr = 1'b1;
				end else if (rmw) begin
					s_d.n = alu_res[7];
					s_d.z = (alu_res == 8'h00);
					if (lo == `LO_ASL || lo == `LO_ASR)
						s_d.c = alu_c; // [RQ20] [RQ21]
					if (lo != `LO_TST) begin
						if (hi == `MODE_INHA)
							s_d.a = alu_res; // [RQ2]
						else if (hi == `MODE_INHX)
							s_d.x = alu_res;
						else begin
							s_d.addr = s_q.ea;
							s_d.wdata = alu_res;
							s_d.wr = 1'b1; // [RQ2] [RQ3]
						end
					end
				end else begin
					s_d.n = alu_res[7]; // [RQ1]
					s_d.z = (alu_res == 8'h00);
					if (lo == `LO_ADC || lo == `LO_ADD) begin
						s_d.h = alu_h;
						s_d.c = alu_c;
					end
					if (alu_wr_a)
						s_d.a = alu_res;
				end
			end
			ST_WRITE: begin
				// Bit branch: carry gets tested bit either way
				s_d.c = s_q.data[lo[3:1]]; // [RQ8]
				// PC already points past the offset byte, the base of the jump
				if (s_q.data[lo[3:1]] ^ lo[0])
					s_d.pc = rel_target(s_q.pc, I_RDATA); // [RQ7] [RQ9]
				else
					s_d.pc = s_q.pc;
				s_d.st = ST_IDLE;
			end
			ST_PUSHL: begin
				s_d.addr = {`STACK_HI, s_q.sp};
				s_d.wdata = s_q.pc[15:8];
				s_d.wr = 1'b1;
				s_d.sp = s_q.sp - 8'h01;
				s_d.st = ST_PUSHH;
			end
			ST_PUSHH: begin
				s_d.pc = rel_target(s_q.pc, s_q.b1); // [RQ15]
				s_d.st = ST_IDLE;
			end
			default: s_d.st = ST_IDLE;
		endcase
	end

	// State register on the synchronised reset
	always_ff @(posedge I_CLOCK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			s_q <= '0;
			s_q.pc <= `RESET_PC;
			s_q.sp <= `RESET_SP;
			s_q.i <= 1'b1;
			s_q.st <= ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign O_ADDR = s_q.addr;
	assign O_WDATA = s_q.wdata;
	assign O_RD = s_q.rd;
	assign O_WR = s_q.wr;
	assign O_PC = s_q.pc;
	assign O_ACC = s_q.a;
	assign O_INDEX = s_q.x;
	assign O_SP = s_q.sp;
	assign O_FLAGS = {s_q.h, s_q.i, s_q.n, s_q.z, s_q.c};
	assign O_FETCH = (s_q.st == ST_FETCH);

	a_clc_carry: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ22]
		(s_q.st == ST_OPA && s_q.op == `OP_CLC) |=> !s_q.c)
		else $error("carry not cleared");
	a_cli_mask: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ22]
		(s_q.st == ST_OPA && s_q.op == `OP_CLI) |=> !s_q.i)
		else $error("mask not cleared");
	a_tst_nowrite: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ3]
		(s_q.st == ST_EXEC && rmw && lo == `LO_TST) |=> !O_WR)
		else $error("test op wrote");
	a_bsr_push: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ15]
		(s_q.st == ST_EXEC && s_q.op == `OP_BSR) |=> O_WR ##1 O_WR ##1 !O_WR)
		else $error("call push order");
	a_bit_carry: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ8]
		(s_q.st == ST_WRITE) |=> s_q.c == $past(s_q.data[lo[3:1]]))
		else $error("tested bit not in carry");
	a_dir_page: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ24]
		(s_q.st == ST_READ && hi == `MODE_DIRM) |-> O_ADDR[15:8] == `ZERO_HI)
		else $error("direct high byte not zero");
	a_bra_taken: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ11]
		(s_q.st == ST_EXEC && s_q.op == 8'h20) |=> s_q.pc == rel_target($past(s_q.pc), $past(s_q.b1)))
		else $error("always branch not taken");
	a_brn_nottaken: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ11]
		(s_q.st == ST_EXEC && s_q.op == 8'h21) |=> s_q.pc == $past(s_q.pc))
		else $error("never branch taken");
	a_mul_split: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ25]
		(s_q.st == ST_OPA && s_q.op == `OP_MUL) |=> {s_q.x, s_q.a} == $past(prod))
		else $error("product split wrong");
	a_mul_flags: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ25]
		(s_q.st == ST_OPA && s_q.op == `OP_MUL) |=> !s_q.h && !s_q.c && s_q.z == $past(s_q.z))
		else $error("multiply flags wrong");

	// Bit branch lands on the next instruction or that plus the offset
	a_bit_fallthru: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ7]
		(s_q.st == ST_WRITE && !(s_q.data[lo[3:1]] ^ lo[0])) |=> s_q.pc == $past(s_q.pc))
		else $error("bit branch fell to wrong address");
	a_bit_jump: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ7]
		(s_q.st == ST_WRITE && (s_q.data[lo[3:1]] ^ lo[0]))
		|=> (s_q.pc - $past(s_q.pc)) == 16'($signed($past(I_RDATA))))
		else $error("bit branch offset wrong");
	// Memory forms write back where they read
	a_rmw_writeback: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ2]
		(s_q.st == ST_EXEC && rmw && hi != `MODE_INHA && hi != `MODE_INHX && lo != `LO_TST)
		|=> O_WR && O_ADDR == $past(s_q.ea))
		else $error("write back to other address");
	a_single_bit_set_page: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ4]
		(s_q.st == ST_EXEC && hi == `OP_BITSC_HI) |=> O_WR && O_ADDR[15:8] == `ZERO_HI)
		else $error("bit set or clear left page zero");
	a_push_low: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ15]
		(s_q.st == ST_EXEC && s_q.op == `OP_BSR)
		|=> O_ADDR == {`STACK_HI, $past(s_q.sp)} && O_WDATA == $past(s_q.pc[7:0]))
		else $error("call low byte push wrong");
	// Shifts: carry source and sign keeping
	a_asl_carry: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ20]
		(s_q.st == ST_EXEC && rmw && lo == `LO_ASL) |=> s_q.c == $past(s_q.data[`SIGN_BIT]))
		else $error("shift left carry wrong");
	a_asr_sign: assert property (@(posedge I_CLOCK) disable iff (!rst_sync_q) // [RQ23]
		(s_q.st == ST_EXEC && rmw && lo == `LO_ASR && hi == `MODE_DIR)
		|=> O_WDATA[`SIGN_BIT] == $past(s_q.data[`SIGN_BIT])
		&& O_WDATA[`SIGN_BIT - 1] == $past(s_q.data[`SIGN_BIT]))
		else $error("shift right lost sign");
endmodule : cpu8_instruction_decode_exec

// File: verif/cpu8_mem_model.sv
`timescale 1ns/1ps
// Zero-wait memory standing on the far side of the core's bus
module cpu8_mem_model (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_rd,
	input wire logic i_wr,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] idle_q;
	int wcount;
	initial idle_q = 8'h5a;
	// Read answers within the strobe cycle; the core takes it at the next edge
	assign o_rdata = i_rd ? mem[i_addr] : idle_q;
	// Idle data flips so a stale byte never passes for an answer
	always @(posedge i_clock) begin
		idle_q <= ~idle_q;
		if (i_wr) mem[i_addr] <= i_wdata;
		wcount <= !i_reset_n ? 0 : wcount + int'(i_wr);
	end
endmodule : cpu8_mem_model

// File: verif/test_cpu8_instruction_decode_exec.sv
`timescale 1ns/1ps
module test_cpu8_instruction_decode_exec;
	logic I_CLOCK = 0;
	logic I_RESET_N = 0;
	logic I_IRQ_PIN = 0;
	logic [15:0] O_ADDR, O_PC;
	logic [7:0] I_RDATA, O_WDATA, O_ACC, O_INDEX, O_SP;
	logic O_RD, O_WR, O_FETCH;
	logic [4:0] O_FLAGS;
	logic [7:0] prog[$];
	logic [31:0] seed = 32'hd832ea26;
	int bad_count = 0;
	int compares = 0;
	// 200 MHz clock
	always #2.5 I_CLOCK = ~I_CLOCK;
	cpu8_instruction_decode_exec u_cpu8_instruction_decode_exec (.I_CLOCK, .I_RESET_N,
		.I_RDATA, .I_IRQ_PIN, .O_ADDR, .O_WDATA, .O_RD, .O_WR, .O_PC, .O_ACC, .O_INDEX,
		.O_SP, .O_FLAGS, .O_FETCH);
	cpu8_mem_model u_cpu8_mem_model (.i_clock(I_CLOCK), .i_reset_n(I_RESET_N),
		.i_addr(O_ADDR), .i_wdata(O_WDATA), .i_rd(O_RD), .i_wr(O_WR), .o_rdata(I_RDATA));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Eight shifts per call so successive bytes are not plain shifts of each other
	function automatic logic [7:0] rnd();
		repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction : rnd
	task automatic put(input logic [15:0] a, input logic [7:0] v);
		u_cpu8_mem_model.mem[a] = v;
	endtask : put
	function automatic logic [7:0] mm(input logic [15:0] a);
		return u_cpu8_mem_model.mem[a];
	endfunction : mm
	// Load program plus a closing self loop, reset, run until the loop is fetched
	task automatic run();
		logic [15:0] e;
		int n;
		@(negedge I_CLOCK);
		I_RESET_N = 0;
		e = 16'h0100 + 16'(prog.size());
		foreach (prog[k]) put(16'h0100 + 16'(k), prog[k]);
		put(e, 8'h20);
		put(e + 16'h0001, 8'hfe);
		repeat (16) @(negedge I_CLOCK);
		I_RESET_N = 1;
		n = 0;
		while (!(O_RD === 1'b1 && O_ADDR === e) && n < 400) begin
			@(negedge I_CLOCK);
			n++;
		end
		if (n >= 400) bad_count++;
		chk({7'h00, O_FETCH}, 8'h01);
		chk(O_PC[15:8], e[15:8]);
		chk(O_PC[7:0], e[7:0]);
		repeat (20) @(negedge I_CLOCK);
		prog = {};
	endtask : run
	task automatic stop_test();
		$display("Counts: %0d compares, %0d mismatches", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	// Watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge I_CLOCK);
		bad_count++;
		stop_test();
	end
	// Main sequence
	initial begin
		int a, b, c, h, r, s, t, m, m2, m3, bv, tk, cond, cl, ci, z, nf;
		repeat (4) begin
			a = rnd(); b = rnd(); m = rnd(); m2 = rnd(); m3 = rnd();
			put(16'h0040, m[7:0]); put(16'h1234, rnd());
			put(16'h0041, m2[7:0]); put(16'h0000, m3[7:0]);
			prog = {8'hab, a[7:0], 8'hab, b[7:0], 8'hb9, 8'h40, 8'hc5, 8'h12, 8'h34,
				8'he4, 8'h41, 8'hfb};
			run();
			s = a + b; c = s >> 8;
			t = (((s & 255) + m + c) & 255) & m2;
			h = ((t & 15) + (m3 & 15)) >> 4; r = t + m3;
			chk(O_ACC, r[7:0]);
			chk(O_FLAGS, {h[0], 1'b1, r[7], r[7:0] == 0, r[8]});
		end
		$display("arithmetic done");
		repeat (4) begin
			a = rnd(); m = rnd(); m2 = rnd(); m3 = rnd();
			put(16'h0050, m[7:0]); put(16'h0051, m2[7:0]); put(16'h0052, m3[7:0]);
			prog = {8'hab, a[7:0], 8'h48, 8'h38, 8'h52, 8'h37, 8'h50, 8'h3d, 8'h51};
			run();
			chk(O_ACC, {a[6:0], 1'b0});
			chk(mm(16'h0052), {m3[6:0], 1'b0});
			chk(mm(16'h0050), {m[7], m[7:1]});
			chk(mm(16'h0051), m2[7:0]);
			chk(u_cpu8_mem_model.wcount[7:0], 8'h02);
			chk(O_FLAGS, {2'b01, m2[7], m2[7:0] == 0, m[0]});
		end
		$display("shift done");
		for (int n = 0; n < 8; n++) begin
			m = rnd(); m2 = rnd();
			put(16'h0050, m[7:0]); put(16'h0051, m2[7:0]);
			prog = {8'(8'h10 + 2 * n), 8'h50, 8'(8'h11 + 2 * n), 8'h51};
			run();
			chk(mm(16'h0050), m[7:0] | 8'(1 << n));
			chk(mm(16'h0051), m2[7:0] & ~8'(1 << n));
		end
		$display("bit set clear done");
		for (int k = 0; k < 16; k++) begin
			m = rnd();
			put(16'h0060, m[7:0]); put(16'h0070, 8'h00);
			prog = {8'(k), 8'h60, 8'h02, 8'h10, 8'h70, 8'h12, 8'h70};
			run();
			bv = (m >> (k >> 1)) & 1;
			tk = (k & 1) ? !bv : bv;
			chk(mm(16'h0070), tk ? 8'h02 : 8'h03);
			chk(O_FLAGS, {4'b0100, bv[0]});
		end
		$display("bit branch done");
		for (int k = 0; k < 32; k++) begin
			a = rnd(); b = rnd(); cl = rnd() & 1; ci = rnd() & 1;
			I_IRQ_PIN = 1'(rnd() & 1);
			put(16'h0070, 8'h00);
			prog = {8'hab, a[7:0], 8'hab, b[7:0]};
			if (cl) prog.push_back(8'h98);
			if (ci) prog.push_back(8'h9a);
			prog = {prog, 8'(8'h20 + k % 16), 8'h02, 8'h10, 8'h70, 8'h12, 8'h70};
			run();
			s = a + b; h = ((a & 15) + (b & 15)) >> 4;
			c = cl ? 0 : s >> 8; z = (s & 255) == 0; nf = (s >> 7) & 1;
			case ((k % 16) >> 1)
				0: cond = 1;
				1: cond = !(c | z);
				2: cond = !c;
				3: cond = !z;
				4: cond = !h;
				5: cond = !nf;
				6: cond = ci;
				default: cond = !I_IRQ_PIN;
			endcase
			tk = (k & 1) ? !cond : cond;
			chk(mm(16'h0070), tk ? 8'h02 : 8'h03);
			chk(O_FLAGS, {h[0], !ci[0], nf[0], z[0], c[0]});
		end
		$display("branch done");
		put(16'h0070, 8'h00);
		prog = {8'had, 8'h02, 8'h10, 8'h70};
		run();
		chk(mm(16'h00ff), 8'h02);
		chk(mm(16'h00fe), 8'h01);
		chk(O_SP, 8'hfd);
		chk(mm(16'h0070), 8'h00);
		$display("call done");
		a = rnd() | 1;
		prog = {8'hab, a[7:0], 8'h42};
		run();
		chk(O_ACC, 8'h00);
		chk(O_INDEX, 8'h00);
		chk(O_FLAGS, {2'b01, a[7], 2'b00});
		$display("multiply done");
		stop_test();
	end
endmodule : test_cpu8_instruction_decode_exec
